/* File: rtl/ssc_synth_control.sv */
// Purpose: APB register front end for the system frequency synthesizer
// Assumes: Core status pins are asynchronous to pclk
// Notes: Answers every access in one wait-free access phase
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps

module ssc_synth_control (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Analog core
	output ssc_pkg::ssc_ctrl_t core_ctrl,
	input wire ssc_pkg::ssc_stat_t core_stat
);

	// Byte address of a register from its index
	function automatic logic [31:0] ssc_addr(input logic [31:0] idx);
		ssc_addr = {idx[29:0], 2'b00};
	endfunction : ssc_addr

	// Precharge hold target in ns for a delay code
	function automatic logic [10:0] ssc_hold_ns(input logic [4:0] d);
		ssc_hold_ns = 11'(d * ssc_pkg::SSC_PDEL_STEP);
	endfunction : ssc_hold_ns

	ssc_pkg::ssc_ctrl_t ctrl_r, ctrl_nxt;
	ssc_pkg::ssc_stat_t s1_r, s2_r, s3_r, stat_r, stat_nxt;
	ssc_pkg::ssc_pc_t pc_r, pc_nxt;
	logic [10:0] ns_r, ns_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
	logic sel_div, sel_loop, sel_cal, sel_stat, sel_vcoi, mapped, wr_en;

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign core_ctrl = ctrl_r;

	// Address decode; writes land only at the completing edge
	assign sel_div = paddr == ssc_addr(ssc_pkg::SSC_DIV_IDX);
	assign sel_loop = paddr == ssc_addr(ssc_pkg::SSC_LOOP_IDX);
	assign sel_cal = paddr == ssc_addr(ssc_pkg::SSC_CAL_IDX);
	assign sel_stat = paddr == ssc_addr(ssc_pkg::SSC_STAT_IDX);
	assign sel_vcoi = paddr == ssc_addr(ssc_pkg::SSC_VCOI_IDX);
	assign mapped = sel_div | sel_loop | sel_cal | sel_stat | sel_vcoi;
	assign wr_en = psel & penable & pready_r & pwrite;

	// Bus answer: pready rises in the first access cycle
	always_comb begin
		pready_nxt = psel & ~penable;
		pslverr_nxt = psel & ~penable & ~mapped;
		prdata_nxt = 32'h0000_0000;
		if (psel && !penable) begin
			if (sel_div) begin
				prdata_nxt[ssc_pkg::SSC_ODIV_LSB +: 7] = ctrl_r.out_div;
				prdata_nxt[ssc_pkg::SSC_HOLD_BIT] =
					ctrl_r.regulator_reference_hold;
				prdata_nxt[ssc_pkg::SSC_REG_ON_BIT] =
					ctrl_r.synth_regulator_on;
				prdata_nxt[ssc_pkg::SSC_ON_BIT] = ctrl_r.synth_on;
			end
			if (sel_loop) begin
				prdata_nxt[ssc_pkg::SSC_AUTO_BIT] =
					ctrl_r.vco_current_auto_select;
				prdata_nxt[ssc_pkg::SSC_PFD_LSB +: 2] =
					ctrl_r.phase_detector_delay_select;
				prdata_nxt[ssc_pkg::SSC_LDIV_LSB +: 7] = ctrl_r.loop_div;
			end
			// Recalibrate is a strobe and reads back as zero
			if (sel_cal) begin
				prdata_nxt[ssc_pkg::SSC_PDEL_LSB +: 5] =
					ctrl_r.precharge_delay;
				prdata_nxt[ssc_pkg::SSC_ICP_LSB +: 5] =
					ctrl_r.charge_pump_current;
			end
			if (sel_stat) begin
				prdata_nxt[ssc_pkg::SSC_DONE_BIT] =
					stat_r.calibration_done;
				prdata_nxt[ssc_pkg::SSC_BAND_LSB +: 6] =
					stat_r.calibrated_vco_band;
				prdata_nxt[ssc_pkg::SSC_ROK_BIT] =
					stat_r.regulator_in_regulation;
				prdata_nxt[ssc_pkg::SSC_LOCK_BIT] = stat_r.locked;
			end
			if (sel_vcoi) begin
				prdata_nxt[5:0] = ctrl_r.vco_min_current;
			end
		end
	end

	// Control fields and precharge sequencer
	always_comb begin
		ctrl_nxt = ctrl_r;
		ctrl_nxt.recalibrate_request = 1'b0;
		if (wr_en && sel_div) begin
			ctrl_nxt.out_div = pwdata[ssc_pkg::SSC_ODIV_LSB +: 7];
			ctrl_nxt.regulator_reference_hold =
				pwdata[ssc_pkg::SSC_HOLD_BIT];
			ctrl_nxt.synth_regulator_on =
				pwdata[ssc_pkg::SSC_REG_ON_BIT];
			ctrl_nxt.synth_on = pwdata[ssc_pkg::SSC_ON_BIT];
		end
		if (wr_en && sel_loop) begin
			ctrl_nxt.vco_current_auto_select =
				pwdata[ssc_pkg::SSC_AUTO_BIT];
			ctrl_nxt.phase_detector_delay_select =
				pwdata[ssc_pkg::SSC_PFD_LSB +: 2];
			ctrl_nxt.loop_div = pwdata[ssc_pkg::SSC_LDIV_LSB +: 7];
		end
		if (wr_en && sel_cal) begin
			ctrl_nxt.recalibrate_request =
				pwdata[ssc_pkg::SSC_RECAL_BIT];
			ctrl_nxt.precharge_delay =
				pwdata[ssc_pkg::SSC_PDEL_LSB +: 5];
			ctrl_nxt.charge_pump_current =
				pwdata[ssc_pkg::SSC_ICP_LSB +: 5];
		end
		// Manual current only matters while auto-select is clear
		if (wr_en && sel_vcoi) begin
			ctrl_nxt.vco_min_current = pwdata[5:0];
		end
		// Elapsed ns counted in clock steps, so release rounds up
		pc_nxt = pc_r;
		ns_nxt = ns_r;
		unique case (pc_r)
			ssc_pkg::SSC_PC_OFF: begin
				ns_nxt = 11'h000;
				if (ctrl_r.synth_on) begin
					pc_nxt = ssc_pkg::SSC_PC_HOLD;
				end
			end
			ssc_pkg::SSC_PC_HOLD: begin
				if (!ctrl_r.synth_on) begin
					pc_nxt = ssc_pkg::SSC_PC_OFF;
				end else if (ns_r >= ssc_hold_ns(ctrl_r.precharge_delay)) begin
					pc_nxt = ssc_pkg::SSC_PC_DONE;
				end else begin
					ns_nxt = ns_r + ssc_pkg::SSC_NS_INC;
				end
			end
			ssc_pkg::SSC_PC_DONE: begin
				if (!ctrl_r.synth_on) begin
					pc_nxt = ssc_pkg::SSC_PC_OFF;
				end
			end
			default: begin
				pc_nxt = ssc_pkg::SSC_PC_OFF;
			end
		endcase
		// Resistors stay in while off so the filter is preset on start
		ctrl_nxt.precharge_engaged = pc_nxt != ssc_pkg::SSC_PC_DONE;
	end

	// Status filter: take the synchronised word once stages agree
	always_comb begin
		stat_nxt = stat_r;
		if (s2_r == s3_r) begin
			stat_nxt = s3_r;
		end
	end

	// Register everything
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= '{synth_on: 1'b0, synth_regulator_on: 1'b0,
				regulator_reference_hold: 1'b0,
				out_div: ssc_pkg::SSC_ODIV_RST,
				loop_div: ssc_pkg::SSC_LDIV_RST,
				vco_current_auto_select: 1'b0,
				vco_min_current: ssc_pkg::SSC_VCOI_RST,
				phase_detector_delay_select: ssc_pkg::SSC_PFD_RST,
				charge_pump_current: ssc_pkg::SSC_ICP_RST,
				precharge_delay: ssc_pkg::SSC_PDEL_RST,
				precharge_engaged: 1'b1, recalibrate_request: 1'b0};
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			stat_r <= '0;
			pc_r <= ssc_pkg::SSC_PC_OFF;
			ns_r <= 11'h000;
			prdata_r <= 32'h0000_0000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			s1_r <= core_stat;
			s2_r <= s1_r;
			s3_r <= s2_r;
			stat_r <= stat_nxt;
			pc_r <= pc_nxt;
			ns_r <= ns_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	// Checks
	sequence s_setup;
		psel && !penable;
	endsequence

	sequence s_write(logic sel);
		wr_en && sel;
	endsequence

	a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
		s_setup |=> pready ##1 !pready)
		else $error("pready not one cycle after setup");

	a_out_div: assert property (@(posedge pclk) disable iff (!presetn)
		s_write(sel_div) |=> core_ctrl.out_div == $past(pwdata[14:8]))
		else $error("output divider not written");

	a_loop_div: assert property (@(posedge pclk) disable iff (!presetn)
		s_write(sel_loop) |=> core_ctrl.loop_div == $past(pwdata[6:0]))
		else $error("loop divider not written");

	a_vco_auto: assert property (@(posedge pclk) disable iff (!presetn)
		s_write(sel_loop) |=> core_ctrl.vco_current_auto_select ==
			$past(pwdata[14]))
		else $error("vco current select not written");

	a_pfd_delay: assert property (@(posedge pclk) disable iff (!presetn)
		s_write(sel_loop) |=> core_ctrl.phase_detector_delay_select ==
			$past(pwdata[13:12]))
		else $error("phase detector delay not written");

	a_prechg_hold: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(core_ctrl.precharge_engaged) |->
			$past(ns_r) >= ssc_hold_ns($past(core_ctrl.precharge_delay))
			&& $past(core_ctrl.synth_on))
		else $error("precharge released early");

	a_prechg_rel: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(core_ctrl.synth_on) && core_ctrl.precharge_delay == 5'h00
		|=> core_ctrl.precharge_engaged ##1 !core_ctrl.precharge_engaged)
		else $error("zero precharge delay not released");

	a_cp_current: assert property (@(posedge pclk) disable iff (!presetn)
		s_write(sel_cal) |=> core_ctrl.charge_pump_current ==
			$past(pwdata[4:0]))
		else $error("charge pump current not written");

	a_stat_read: assert property (@(posedge pclk) disable iff (!presetn)
		s_setup ##0 sel_stat |=> prdata[11:0] ==
			{$past(stat_r.calibration_done),
			$past(stat_r.calibrated_vco_band), 3'b000,
			$past(stat_r.regulator_in_regulation), $past(stat_r.locked)})
		else $error("status read mismatch");

	a_stat_filter: assert property (@(posedge pclk) disable iff (!presetn)
		s2_r == s3_r |=> stat_r == $past(s3_r))
		else $error("status filter did not follow");

	a_synth_on: assert property (@(posedge pclk) disable iff (!presetn)
		s_write(sel_div) |=> core_ctrl.synth_on == $past(pwdata[0]) &&
			core_ctrl.synth_regulator_on == $past(pwdata[1]))
		else $error("enable bits not written");

	a_recal_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		s_write(sel_cal) ##0 pwdata[15] |=>
			core_ctrl.recalibrate_request ##1 !core_ctrl.recalibrate_request)
		else $error("recalibrate not a single pulse");

	a_vcoi_write: assert property (@(posedge pclk)
		disable iff (!presetn) s_write(sel_vcoi) |=>
		core_ctrl.vco_min_current == $past(pwdata[5:0]))
		else $error("manual vco current not written");

	a_pdel_write: assert property (@(posedge pclk)
		disable iff (!presetn) s_write(sel_cal) |=>
		core_ctrl.precharge_delay ==
		$past(pwdata[ssc_pkg::SSC_PDEL_LSB +: 5]))
		else $error("precharge delay not written");

	// Powering down must put the resistors back in for the next start
	a_prechg_reeng: assert property (@(posedge pclk)
		disable iff (!presetn) !core_ctrl.synth_on |=>
		core_ctrl.precharge_engaged)
		else $error("precharge not engaged while off");

	a_done_hold: assert property (@(posedge pclk)
		disable iff (!presetn) s2_r != s3_r |=> stat_r == $past(stat_r))
		else $error("status changed while stages disagree");

	a_recal_quiet: assert property (@(posedge pclk)
		disable iff (!presetn)
		!(wr_en && sel_cal && pwdata[ssc_pkg::SSC_RECAL_BIT]) |=>
		!core_ctrl.recalibrate_request)
		else $error("recalibrate pulse without request");

	a_bus_error: assert property (@(posedge pclk) disable iff (!presetn)
		s_setup ##0 !mapped |=> pslverr && pready && prdata == 32'h0000_0000)
		else $error("unmapped access not refused");

	a_rdata_idle: assert property (@(posedge pclk) disable iff (!presetn)
		!(psel && !penable) |=> prdata == 32'h0000_0000 && !pslverr)
		else $error("read data outside access cycle");

	a_ok_read: assert property (@(posedge pclk)
		disable iff (!presetn) s_setup ##0 sel_stat |=>
		prdata[ssc_pkg::SSC_ROK_BIT] == $past(stat_r.regulator_in_regulation))
		else $error("regulator status read mismatch");
endmodule : ssc_synth_control

/* File: rtl/ssc_pkg.sv */
// Purpose: Shared constants and carriers for the synthesizer control block
// Assumes: 32-bit APB, register index = printed offset, byte address = 4x
// Notes: Control and status travel to and from the analog core as structs
package ssc_pkg;
	// Register indices as printed; the bus decodes four times these
	localparam logic [31:0] SSC_DIV_IDX = 32'h50003310;
	localparam logic [31:0] SSC_LOOP_IDX = 32'h50003312;
	localparam logic [31:0] SSC_CAL_IDX = 32'h50003314;
	localparam logic [31:0] SSC_STAT_IDX = 32'h50003316;
	localparam logic [31:0] SSC_VCOI_IDX = 32'h50003318;

	// Divider control fields
	localparam int SSC_ODIV_LSB = 8;
	localparam int SSC_HOLD_BIT = 2;
	localparam int SSC_REG_ON_BIT = 1;
	localparam int SSC_ON_BIT = 0;
	// Loop control fields
	localparam int SSC_AUTO_BIT = 14;
	localparam int SSC_PFD_LSB = 12;
	localparam int SSC_LDIV_LSB = 0;
	// Calibration control fields
	localparam int SSC_RECAL_BIT = 15;
	localparam int SSC_PDEL_LSB = 10;
	localparam int SSC_ICP_LSB = 0;
	// Status fields
	localparam int SSC_DONE_BIT = 11;
	localparam int SSC_BAND_LSB = 5;
	localparam int SSC_ROK_BIT = 1;
	localparam int SSC_LOCK_BIT = 0;

	// Reset values
	localparam logic [6:0] SSC_ODIV_RST = 7'h01;
	localparam logic [6:0] SSC_LDIV_RST = 7'h06;
	localparam logic [1:0] SSC_PFD_RST = 2'h2;
	localparam logic [4:0] SSC_PDEL_RST = 5'h0F;
	localparam logic [4:0] SSC_ICP_RST = 5'h09;
	localparam logic [5:0] SSC_VCOI_RST = 6'h00;

	// Precharge timing: one delay step is 48 ns, clock period 10 ns
	localparam int SSC_PDEL_STEP_NS = 48;
	localparam int SSC_CLK_NS = 10;
	localparam logic [10:0] SSC_PDEL_STEP = 11'(SSC_PDEL_STEP_NS);
	localparam logic [10:0] SSC_NS_INC = 11'(SSC_CLK_NS);

	// Settings driven into the analog core
	typedef struct packed {
		logic synth_on;
		logic synth_regulator_on;
		logic regulator_reference_hold;
		logic [6:0] out_div;
		logic [6:0] loop_div;
		logic vco_current_auto_select;
		logic [5:0] vco_min_current;
		logic [1:0] phase_detector_delay_select;
		logic [4:0] charge_pump_current;
		logic [4:0] precharge_delay;
		logic precharge_engaged;
		logic recalibrate_request;
	} ssc_ctrl_t;

	// Status reported by the analog core
	typedef struct packed {
		logic calibration_done;
		logic [5:0] calibrated_vco_band;
		logic regulator_in_regulation;
		logic locked;
	} ssc_stat_t;

	// Precharge sequencer states
	typedef enum logic [1:0] {
		SSC_PC_OFF = 2'b00,
		SSC_PC_HOLD = 2'b01,
		SSC_PC_DONE = 2'b10
	} ssc_pc_t;
endpackage : ssc_pkg

/* File: verif/ssc_core_model.sv */
// Purpose: Behavioural analog synthesizer core facing the control block
// Assumes: Calibration length is an arbitrary count of 21 cycles
// Notes: Band answer is loop_div[5:0] xor 6'h2A so the bench can predict it
`timescale 1ns/1ps
module ssc_core_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Settings in, status out
	input wire ssc_pkg::ssc_ctrl_t ctrl,
	output ssc_pkg::ssc_stat_t stat
);
	logic [4:0] cal_cnt;
	logic was_on;
	// Calibration restarts on enable or request; powered down clears done, lock and band
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat <= '0;
			cal_cnt <= 5'h00;
			was_on <= 1'b0;
		end else begin
			was_on <= ctrl.synth_on;
			stat.regulator_in_regulation <= ctrl.synth_regulator_on;
			if (!ctrl.synth_on) begin
				stat.calibration_done <= 1'b0;
				stat.locked <= 1'b0;
				stat.calibrated_vco_band <= 6'h00;
			end else if (!was_on || ctrl.recalibrate_request) begin
				cal_cnt <= 5'h14;
				stat.calibration_done <= 1'b0;
				stat.locked <= 1'b0;
			end else if (cal_cnt != 5'h00) begin
				cal_cnt <= cal_cnt - 5'h01;
			end else begin
				stat.calibration_done <= 1'b1;
				stat.calibrated_vco_band <= ctrl.loop_div[5:0] ^ 6'h2A;
				stat.locked <= 1'b1;
			end
		end
	end
endmodule : ssc_core_model

/* File: verif/system_synth_control_bench.sv */
// Purpose: Self-checking bench for the synthesizer control registers
// Assumes: Zero-wait APB slave, status synchroniser of four edges
// Notes: Reads note their expected word; a monitor compares at pready
`timescale 1ns/1ps
module system_synth_control_bench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [31:0] paddr, pwdata, prdata, r, vd, vl, vc, vv;
	ssc_pkg::ssc_ctrl_t core_ctrl;
	ssc_pkg::ssc_stat_t core_stat;
	int mismatches, checked, seed, n, p;
	logic [32:0] notes[$];
	logic [4:0] dl[3];
	localparam logic [31:0] A_DIV = ssc_pkg::SSC_DIV_IDX << 2;
	localparam logic [31:0] A_LOOP = ssc_pkg::SSC_LOOP_IDX << 2;
	localparam logic [31:0] A_CAL = ssc_pkg::SSC_CAL_IDX << 2;
	localparam logic [31:0] A_STAT = ssc_pkg::SSC_STAT_IDX << 2;
	localparam logic [31:0] A_VCOI = ssc_pkg::SSC_VCOI_IDX << 2;

	ssc_synth_control DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.core_ctrl(core_ctrl), .core_stat(core_stat));
	ssc_core_model core (.pclk(pclk), .presetn(presetn), .ctrl(core_ctrl),
		.stat(core_stat));

	// Free-running bus clock
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// Leaves the request up so the next setup may follow at once
	task automatic apb(input logic wr, input logic [31:0] a, d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
	endtask : apb

	task automatic rd(input logic [31:0] a, input logic [32:0] exp);
		notes.push_back(exp);
		apb(1'b0, a, 32'h00000000);
	endtask : rd

	task automatic idle();
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : idle

	task automatic print_verdict();
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : print_verdict

	// Oldest note against each completed read
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite)
			chk({pslverr, prdata}, notes.pop_front());
	end

	// Watchdog far beyond the few hundred cycles of the sequence
	initial begin
		#200000;
		mismatches++;
		print_verdict();
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata, presetn} = '0;
		seed = 32'haa48;
		dl = '{5'h00, 5'h1F, 5'h0B};
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(A_DIV, 33'h000000100);
		rd(A_LOOP, 33'h000002006);
		rd(A_CAL, 33'h000003C09);
		rd(A_STAT, 33'h000000000);
		rd(A_VCOI, 33'h000000000);
		rd(A_DIV + 32'h40, 33'h100000000);
		idle();
		chk({core_ctrl.out_div, core_ctrl.loop_div, core_ctrl.precharge_engaged,
			core_ctrl.phase_detector_delay_select, core_ctrl.charge_pump_current,
			core_ctrl.precharge_delay},
			{7'h01, 7'h06, 1'b1, 2'h2, 5'h09, 5'h0F});
		// Random settings, every delay code once
		for (int i = 0; i < 4; i++) begin
			r = $random(seed);
			vd = {16'h0, 1'b0, r[6:0], 5'h00, r[7], 2'b00};
			vl = {16'h0, 1'b0, r[8], i[1:0], 5'h00, r[15:9]};
			vc = {16'h0, 1'b0, r[20:16], 5'h00, r[25:21]};
			vv = {26'h0, r[31:26]};
			apb(1'b1, A_DIV, vd);
			apb(1'b1, A_LOOP, vl);
			apb(1'b1, A_CAL, vc);
			apb(1'b1, A_VCOI, vv);
			apb(1'b1, A_STAT, 32'h0000FFFF);
			rd(A_DIV, {1'b0, vd});
			rd(A_LOOP, {1'b0, vl});
			rd(A_CAL, {1'b0, vc});
			rd(A_VCOI, {1'b0, vv});
			rd(A_STAT, 33'h000000000);
			idle();
			chk({core_ctrl.out_div, core_ctrl.regulator_reference_hold,
				core_ctrl.vco_current_auto_select, core_ctrl.loop_div,
				core_ctrl.phase_detector_delay_select, core_ctrl.precharge_delay,
				core_ctrl.charge_pump_current, core_ctrl.vco_min_current},
				{vd[14:8], vd[2], vl[14], vl[6:0], vl[13:12], vc[14:10], vc[4:0],
				vv[5:0]});
		end
		// Precharge hold length for shortest, longest and a middle delay
		foreach (dl[k]) begin
			apb(1'b1, A_CAL, {16'h0, 1'b0, dl[k], 10'h009});
			apb(1'b1, A_DIV, 32'h00000103);
			idle();
			n = 0;
			do begin
				@(negedge pclk);
				n++;
			end while (core_ctrl.precharge_engaged === 1'b1 && n < 400);
			chk(n * 10 >= dl[k] * 48 && n <= dl[k] * 48 / 10 + 4, 1);
			chk({core_ctrl.synth_on, core_ctrl.synth_regulator_on}, 2'b11);
			@(posedge pclk);
			apb(1'b1, A_DIV, 32'h00000000);
			idle();
			repeat (2) @(negedge pclk);
			chk({core_ctrl.synth_on, core_ctrl.precharge_engaged}, 2'b01);
			@(posedge pclk);
		end
		// Calibration, lock, then a recalibration request
		apb(1'b1, A_DIV, 32'h00000103);
		idle();
		repeat (40) @(posedge pclk);
		rd(A_STAT, {21'h1, vl[5:0] ^ 6'h2A, 5'h03});
		apb(1'b1, A_CAL, 32'h0000BC09);
		// Release without an edge so the one-cycle strobe is still seen
		psel <= 1'b0;
		penable <= 1'b0;
		p = 0;
		repeat (4) begin
			@(negedge pclk);
			p += int'(core_ctrl.recalibrate_request === 1'b1);
		end
		chk(p, 1);
		@(posedge pclk);
		repeat (6) @(posedge pclk);
		rd(A_STAT, {21'h0, vl[5:0] ^ 6'h2A, 5'h02});
		idle();
		repeat (40) @(posedge pclk);
		rd(A_STAT, {21'h1, vl[5:0] ^ 6'h2A, 5'h03});
		rd(A_CAL, 33'h000003C09);
		apb(1'b1, A_DIV, 32'h00000000);
		idle();
		repeat (10) @(posedge pclk);
		rd(A_STAT, 33'h000000000);
		idle();
		print_verdict();
	end
endmodule : system_synth_control_bench
